// >>> rtl/bal_pkg.sv
// shared constants, types and bus carriers of the byte arithmetic and logic unit
package bal_pkg;

	// register byte offsets on the AHB-Lite slave (low address byte)
	localparam logic [7:0] OFS_DEST_LO = 8'h00;
	localparam logic [7:0] OFS_SRC = 8'h04;
	localparam logic [7:0] OFS_DEST_HI = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_FLAGS = 8'h10;

	// field positions in the status flag byte
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;

	// command register layout
	localparam int unsigned CMD_OP_MSB = 4;
	localparam int unsigned CMD_BUSY_BIT = 8;

	// values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// operand constants
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;

	// operation codes, numbered from zero in this order
	typedef enum logic [4:0] {
		OP_NOP,
		OP_ADD,
		OP_ADD_CARRY,
		OP_WORD_ADD_IMMEDIATE,
		OP_SUB,
		OP_SUBTRACT_IMMEDIATE,
		OP_SUBTRACT_WITH_BORROW,
		OP_SUBTRACT_IMMEDIATE_WITH_BORROW,
		OP_WORD_SUBTRACT_IMMEDIATE,
		OP_AND,
		OP_AND_IMMEDIATE,
		OP_OR,
		OP_OR_IMMEDIATE,
		OP_EXCLUSIVE_OR,
		OP_ONES_COMPLEMENT,
		OP_TWOS_COMPLEMENT,
		OP_SET_BITS_BY_MASK,
		OP_CLEAR_BITS_BY_MASK,
		OP_INCREMENT
	} bal_op_e;

	// execution sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_WORD_HI
	} bal_state_e;

	// byte adder or subtractor outcome
	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic h;
		logic v;
	} bal_alu8_s;

	// AHB-Lite request side as seen by the slave
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} bal_ahb_req_s;

	// AHB-Lite slave response
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} bal_ahb_rsp_s;

endpackage : bal_pkg

// >>> rtl/bal_byte_arith_logic_unit.sv
// eight-bit arithmetic and logic unit with an AHB-Lite register slave
`timescale 1ns/1ns

module bal_byte_arith_logic_unit (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire bal_pkg::bal_ahb_req_s i_ahb,
	output bal_pkg::bal_ahb_rsp_s o_ahb,
	output logic [15:0] o_word,
	output logic [7:0] o_flags
);
	import bal_pkg::*;

	logic [7:0] dest_lo, dest_hi, src, flags, ph_addr, next_lo, next_hi, next_flags;
	logic [4:0] last_op;
	bal_state_e state;
	logic word_carry, word_sub, wr_pend, rd_pend, accept, rd_accept, wr_do, cmd_go, flags_upd, word_start;
	logic next_word_carry, next_word_sub;
	bal_ahb_rsp_s rsp;
	bal_op_e op;
	logic [31:0] rd_word;

	// byte add with carry in; carry, half carry and signed overflow out
	function automatic bal_alu8_s add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		bal_alu8_s r;
		logic [8:0] s;
		logic [4:0] n;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r.res = s[7:0];
		r.c = s[8];
		r.h = n[4];
		r.v = (a[7] == b[7]) && (s[7] != a[7]);
		return r;
	endfunction : add8

	// byte subtract with borrow in; borrow out lands in the carry position
	function automatic bal_alu8_s sub8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		bal_alu8_s r;
		logic [8:0] s;
		logic [4:0] n;
		s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
		n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
		r.res = s[7:0];
		r.c = s[8];
		r.h = n[4];
		r.v = (a[7] != b[7]) && (s[7] != a[7]);
		return r;
	endfunction : sub8

	// zero, negative and overflow from a byte result, other flags untouched
	function automatic logic [7:0] flags_znv(input logic [7:0] f, input logic [7:0] res, input logic v);
		logic [7:0] r;
		r = f;
		r[FLAG_Z] = (res == ZERO_BYTE);
		r[FLAG_N] = res[7];
		r[FLAG_V] = v;
		return r;
	endfunction : flags_znv

	// arithmetic flags: adds carry and half carry to the logic set
	function automatic logic [7:0] flags_arith(input logic [7:0] f, input bal_alu8_s a);
		logic [7:0] r;
		r = flags_znv(f, a.res, a.v);
		r[FLAG_C] = a.c;
		r[FLAG_H] = a.h;
		return r;
	endfunction : flags_arith

	// address phase taken whenever the bus is ready, this slave is selected and the transfer is NONSEQ or SEQ
	assign accept = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
	assign rd_accept = accept && !i_ahb.hwrite;
	// write data is used only once our own data phase is allowed to end
	assign wr_do = wr_pend && rsp.hreadyout;
	assign cmd_go = wr_do && (ph_addr == OFS_CMD);
	assign op = bal_op_e'(i_ahb.hwdata[CMD_OP_MSB:0]);

	// outputs are the flops themselves
	assign o_ahb = rsp;
	assign o_word = {dest_hi, dest_lo};
	assign o_flags = flags;

	// data-phase bookkeeping; address is frozen while the data phase is stretched
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			ph_addr <= RST_BYTE;
		end
		else if (rsp.hreadyout)
		begin
			wr_pend <= accept && i_ahb.hwrite;
			rd_pend <= rd_accept;
			ph_addr <= accept ? i_ahb.haddr[7:0] : ph_addr;
		end
		else if (rd_pend && (state == ST_IDLE))
		begin
			rd_pend <= 1'b0;
		end
	end

	// read multiplexer; unmapped offsets read as zero
	always_comb
	begin
		rd_word = RST_WORD;
		if (ph_addr == OFS_DEST_LO)
		begin
			rd_word = {24'h00_0000, dest_lo};
		end
		else if (ph_addr == OFS_SRC)
		begin
			rd_word = {24'h00_0000, src};
		end
		else if (ph_addr == OFS_DEST_HI)
		begin
			rd_word = {24'h00_0000, dest_hi};
		end
		else if (ph_addr == OFS_CMD)
		begin
			rd_word = {23'h0, (state == ST_WORD_HI), 3'h0, last_op};
		end
		else if (ph_addr == OFS_FLAGS)
		begin
			rd_word = {24'h00_0000, flags};
		end
	end

	// reads always get at least one wait state so a write just before them is seen
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rsp.hrdata <= RST_WORD;
			rsp.hreadyout <= 1'b1;
			rsp.hresp <= 1'b0;
		end
		else
		begin
			rsp.hresp <= 1'b0;
			if (word_start || rd_accept)
			begin
				rsp.hreadyout <= 1'b0;
			end
			else if (rd_pend)
			begin
				// hold the read off until the high byte of a word op is in place
				if (state == ST_IDLE)
				begin
					rsp.hreadyout <= 1'b1;
					rsp.hrdata <= rd_word;
				end
			end
			else if (state == ST_WORD_HI)
			begin
				rsp.hreadyout <= 1'b1;
			end
		end
	end

	// operation datapath, evaluated in the cycle the command write completes
	always_comb
	begin
		bal_alu8_s ar;
		ar = '0;
		next_lo = dest_lo;
		next_hi = dest_hi;
		next_flags = flags;
		flags_upd = 1'b0;
		word_start = 1'b0;
		next_word_carry = word_carry;
		next_word_sub = word_sub;
		case (state)
			ST_IDLE:
			begin
				if (cmd_go)
				begin
					flags_upd = 1'b1;
					case (op)
						OP_ADD, OP_ADD_CARRY:
						begin
							ar = add8(dest_lo, src, (op == OP_ADD_CARRY) && flags[FLAG_C]);
							next_lo = ar.res;
							next_flags = flags_arith(flags, ar);
						end
						OP_SUB, OP_SUBTRACT_IMMEDIATE:
						begin
							ar = sub8(dest_lo, src, 1'b0);
							next_lo = ar.res;
							next_flags = flags_arith(flags, ar);
						end
						OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_IMMEDIATE_WITH_BORROW:
						begin
							ar = sub8(dest_lo, src, flags[FLAG_C]);
							next_lo = ar.res;
							next_flags = flags_arith(flags, ar);
						end
						OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE:
						begin
							// low byte now, carry parked for the high byte next cycle
							ar = (op == OP_WORD_ADD_IMMEDIATE) ? add8(dest_lo, src, 1'b0) : sub8(dest_lo, src, 1'b0);
							next_lo = ar.res;
							next_word_carry = ar.c;
							next_word_sub = (op == OP_WORD_SUBTRACT_IMMEDIATE);
							word_start = 1'b1;
							flags_upd = 1'b0;
						end
						OP_AND, OP_AND_IMMEDIATE:
						begin
							next_lo = dest_lo & src;
							next_flags = flags_znv(flags, next_lo, 1'b0);
						end
						OP_OR, OP_OR_IMMEDIATE, OP_SET_BITS_BY_MASK:
						begin
							next_lo = dest_lo | src;
							next_flags = flags_znv(flags, next_lo, 1'b0);
						end
						OP_CLEAR_BITS_BY_MASK:
						begin
							next_lo = dest_lo & (ALL_ONES - src);
							next_flags = flags_znv(flags, next_lo, 1'b0);
						end
						OP_EXCLUSIVE_OR:
						begin
							next_lo = dest_lo ^ src;
							next_flags = flags_znv(flags, next_lo, 1'b0);
						end
						OP_ONES_COMPLEMENT:
						begin
							// carry is always set, half carry stays as it was
							next_lo = ALL_ONES - dest_lo;
							next_flags = flags_znv(flags, next_lo, 1'b0);
							next_flags[FLAG_C] = 1'b1;
						end
						OP_TWOS_COMPLEMENT:
						begin
							ar = sub8(ZERO_BYTE, dest_lo, 1'b0);
							next_lo = ar.res;
							next_flags = flags_arith(flags, ar);
						end
						OP_INCREMENT:
						begin
							// carry and half carry are deliberately left alone
							ar = add8(dest_lo, ONE_BYTE, 1'b0);
							next_lo = ar.res;
							next_flags = flags_znv(flags, ar.res, ar.v);
						end
						default:
						begin
							// unknown codes and the no-op change nothing
							flags_upd = 1'b0;
						end
					endcase
				end
			end
			ST_WORD_HI:
			begin
				// second cycle: high byte takes the carry, flags cover all 16 bits
				ar = word_sub ? sub8(dest_hi, ZERO_BYTE, word_carry) : add8(dest_hi, ZERO_BYTE, word_carry);
				next_hi = ar.res;
				flags_upd = 1'b1;
				next_flags[FLAG_N] = ar.res[7];
				next_flags[FLAG_Z] = ({ar.res, dest_lo} == 16'h0000);
				next_flags[FLAG_V] = word_sub ? (dest_hi[7] && !ar.res[7]) : (!dest_hi[7] && ar.res[7]);
				next_flags[FLAG_C] = word_sub ? (ar.res[7] && !dest_hi[7]) : (!ar.res[7] && dest_hi[7]);
				next_flags[FLAG_S] = next_flags[FLAG_N] ^ next_flags[FLAG_V];
			end
		endcase
	end

	// destination pair: software load or operation result
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			dest_lo <= RST_BYTE;
			dest_hi <= RST_BYTE;
		end
		else
		begin
			dest_lo <= (wr_do && (ph_addr == OFS_DEST_LO)) ? i_ahb.hwdata[7:0] : next_lo;
			dest_hi <= (wr_do && (ph_addr == OFS_DEST_HI)) ? i_ahb.hwdata[7:0] : next_hi;
		end
	end

	// source register or immediate operand
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			src <= RST_BYTE;
		end
		else if (wr_do && (ph_addr == OFS_SRC))
		begin
			src <= i_ahb.hwdata[7:0];
		end
	end

	// status flags; an operation and a software write never share a cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			flags <= RST_FLAGS;
		end
		else if (flags_upd)
		begin
			flags <= next_flags;
		end
		else if (wr_do && (ph_addr == OFS_FLAGS))
		begin
			flags <= i_ahb.hwdata[7:0];
		end
	end

	// sequencer for the two-cycle word operations
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= ST_IDLE;
			word_carry <= 1'b0;
			word_sub <= 1'b0;
			last_op <= RST_BYTE[4:0];
		end
		else
		begin
			word_carry <= next_word_carry;
			word_sub <= next_word_sub;
			if (cmd_go && (state == ST_IDLE))
			begin
				last_op <= i_ahb.hwdata[CMD_OP_MSB:0];
			end
			case (state)
				ST_IDLE:
				begin
					if (word_start)
					begin
						state <= ST_WORD_HI;
					end
				end
				ST_WORD_HI:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule : bal_byte_arith_logic_unit

// >>> verif/bal_monitor.sv
// concurrent checks on the unit's bus and result ports
`timescale 1ns/1ns
module bal_monitor
	import bal_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire bal_pkg::bal_ahb_req_s i_ahb,
	input wire bal_pkg::bal_ahb_rsp_s o_ahb,
	input wire logic [15:0] o_word,
	input wire logic [7:0] o_flags
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic cmd_ph;
	logic go;
	logic is_word;
	logic is_logic;
	logic is_byte;
	bal_op_e op;
	// remembers a command write whose data phase is open
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cmd_ph <= 1'b0;
		else if (i_ahb.hready)
			cmd_ph <= i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hwrite && i_ahb.haddr[7:0] == OFS_CMD;
	end
	// opcode decode at the edge that executes it; codes past the table do nothing
	assign op = bal_op_e'(i_ahb.hwdata[CMD_OP_MSB:0]);
	assign go = cmd_ph && i_ahb.hready;
	assign is_word = op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE};
	assign is_logic = op inside {OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR,
		OP_SET_BITS_BY_MASK, OP_CLEAR_BITS_BY_MASK};
	assign is_byte = op != OP_NOP && op <= OP_INCREMENT && !is_word;
	// second word cycle holds the bus exactly once
	sequence s_stall;
		!o_ahb.hreadyout ##1 o_ahb.hreadyout;
	endsequence
	word_stall_a: assert property (go && is_word |=> s_stall)
		else $error("word stall is not one cycle");
	word_flags_a: assert property (go && is_word |=> ##1
		o_flags[FLAG_S] == (o_flags[FLAG_N] ^ o_flags[FLAG_V]) && o_flags[FLAG_N] == o_word[15]
		&& o_flags[FLAG_Z] == (o_word == 16'h0000) && $stable(o_flags[FLAG_H]))
		else $error("word flags wrong");
	byte_keep_a: assert property (go && is_byte |=>
		o_word[15:8] == $past(o_word[15:8]) && $stable(o_flags[FLAG_S]))
		else $error("byte op touched high byte or sign");
	byte_zero_a: assert property (go && is_byte |=>
		o_flags[FLAG_Z] == (o_word[7:0] == ZERO_BYTE) && o_flags[FLAG_N] == o_word[7])
		else $error("byte zero or negative flag wrong");
	logic_keep_a: assert property (go && is_logic |=>
		!o_flags[FLAG_V] && $stable(o_flags[FLAG_C]) && $stable(o_flags[FLAG_H]))
		else $error("logic op flags wrong");
	ones_comp_a: assert property (go && op == OP_ONES_COMPLEMENT |=>
		o_word[7:0] == ~$past(o_word[7:0]) && o_flags[FLAG_C])
		else $error("ones complement wrong");
	twos_comp_a: assert property (go && op == OP_TWOS_COMPLEMENT |=>
		o_word[7:0] == ZERO_BYTE - $past(o_word[7:0]) && o_flags[FLAG_C] == (o_word[7:0] != ZERO_BYTE))
		else $error("twos complement wrong");
	incr_check_a: assert property (go && op == OP_INCREMENT |=>
		o_word[7:0] == $past(o_word[7:0]) + ONE_BYTE)
		else $error("increment wrong");
endmodule : bal_monitor
bind bal_byte_arith_logic_unit bal_monitor bal_monitor_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_ahb(i_ahb), .o_ahb(o_ahb), .o_word(o_word), .o_flags(o_flags));

// >>> verif/bal_ahb_host.sv
// bus master standing in for the core side of the register bus
`timescale 1ns/1ns
module bal_ahb_host
	import bal_pkg::*;
(
	input wire logic i_core_clk,
	input wire bal_pkg::bal_ahb_rsp_s i_rsp,
	output bal_pkg::bal_ahb_req_s o_req
);
	logic [31:0] haddr = RST_WORD;
	logic [31:0] hwdata = RST_WORD;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	// single slave, so its readiness is the bus readiness
	assign o_req = '{1'b1, haddr, htrans, hwrite, 3'h2, hwdata, i_rsp.hreadyout};
	// one whole-word transfer; no pipelining, so waits never overlap
	task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		haddr <= {24'h000000, adr};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge i_core_clk);
		while (i_rsp.hreadyout !== 1'b1)
			@(posedge i_core_clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge i_core_clk);
		while (i_rsp.hreadyout !== 1'b1)
			@(posedge i_core_clk);
		rd = i_rsp.hrdata;
		hwdata <= ~wd; // released data must not look still valid
	endtask : xfer
endmodule : bal_ahb_host

// >>> verif/testbench.sv
// self-checking bench for the byte arithmetic and logic unit
`timescale 1ns/1ns
module testbench;
	import bal_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	bal_ahb_req_s ahb_req;
	bal_ahb_rsp_s ahb_rsp;
	logic [15:0] word;
	logic [7:0] flags;
	logic [31:0] rd;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	// op, high, low, operand, expected pair, expected flags; flags preset to F1 each time
	logic [55:0] tbl [21] = '{56'h01_00_88_88_0010_F9, 56'h02_00_0F_00_0010_F0, 56'h04_00_10_10_0000_D2,
		56'h05_00_00_01_00FF_F5, 56'h06_00_80_00_007F_F8, 56'h07_00_05_04_0000_D2, 56'h09_00_F0_0F_0000_F3,
		56'h0A_00_C3_81_0081_F5, 56'h0B_00_00_00_0000_F3, 56'h0C_00_40_82_00C2_F5, 56'h0D_00_AA_FF_0055_F1,
		56'h0E_00_FF_00_0000_F3, 56'h0F_00_80_00_0080_DD, 56'h10_00_01_80_0081_F5, 56'h11_00_FF_0F_00F0_F5,
		56'h12_00_7F_00_0080_FD, 56'h00_00_5A_33_005A_F1, 56'h13_00_5A_33_005A_F1, 56'h03_7F_FF_01_8000_EC,
		56'h08_00_00_01_FFFF_F5, 56'h08_00_3F_3F_0000_E2};
	bal_byte_arith_logic_unit bal_byte_arith_logic_unit_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_ahb(ahb_req), .o_ahb(ahb_rsp), .o_word(word), .o_flags(flags));
	bal_ahb_host bal_ahb_host_inst (.i_core_clk(i_core_clk), .i_rsp(ahb_rsp), .o_req(ahb_req));
	// 50 ns period
	always #25 i_core_clk = ~i_core_clk;
	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bal_ahb_host_inst.xfer(1'b1, a, {24'h000000, d}, rd);
	endtask : wr
	task automatic rr(input logic [7:0] a);
		bal_ahb_host_inst.xfer(1'b0, a, RST_WORD, rd);
	endtask : rr
	// reset values, and an unmapped place that ignores writes
	task automatic t_reset();
		chk({16'h0000, word}, RST_WORD);
		chk({24'h000000, flags}, {24'h000000, RST_FLAGS});
		wr(8'h14, 8'hFF);
		rr(8'h14);
		chk(rd, RST_WORD);
		rr(OFS_CMD);
		chk(rd, RST_WORD);
		chk({31'h0, ahb_rsp.hresp}, RST_WORD);
	endtask : t_reset
	// every opcode with preset flags, so kept flags show as well
	task automatic t_ops();
		logic [55:0] r;
		for (int i = 0; i < 21; i++)
		begin
			r = tbl[i];
			wr(OFS_FLAGS, 8'hF1);
			wr(OFS_DEST_HI, r[47:40]);
			wr(OFS_DEST_LO, r[39:32]);
			wr(OFS_SRC, r[31:24]);
			wr(OFS_CMD, r[55:48]);
			rr(OFS_CMD);
			chk(rd, {27'h0, r[52:48]});
			chk({16'h0000, word}, {16'h0000, r[23:8]});
			chk({24'h000000, flags}, {24'h000000, r[7:0]});
			rr(OFS_FLAGS);
			chk(rd, {24'h000000, r[7:0]});
		end
	endtask : t_ops
	// word op followed at once by a write that its stall stretches
	task automatic t_back();
		wr(OFS_DEST_HI, 8'h00);
		wr(OFS_DEST_LO, 8'hFF);
		wr(OFS_SRC, 8'h01);
		wr(OFS_CMD, {3'h0, OP_WORD_ADD_IMMEDIATE});
		wr(OFS_DEST_LO, 8'h12);
		@(posedge i_core_clk);
		chk({16'h0000, word}, 32'h0000_0112);
	endtask : t_back
	// cycle ceiling cuts a hang short
	always @(posedge i_core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	// reset for three cycles, then the scenarios
	initial
	begin
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		@(posedge i_core_clk);
		t_reset();
		t_ops();
		t_back();
		give_verdict();
	end
endmodule : testbench
